// ===== hdl/rbs_pkg.sv
// Package: constants, register map and state codes for the reboot sequencer
package rbs_pkg;

   // ----------------------------------------------------------------
   // Register command codes
   // ----------------------------------------------------------------
   localparam logic [7:0] CMP_RBT_PIN_SEL_ADDR = 8'hf7;
   localparam logic [7:0] REBOOT_CTRL_ADDR = 8'hfd;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int PIN_RESTART_ENABLE_BIT = 7;
   localparam int RESTART_PIN_PICK_LSB = 4;
   localparam int CMP_PICK_LSB = 0;
   localparam int RESTART_INIT_MODE_LSB = 4;
   localparam int REBOOT_CMD_BIT = 3;
   localparam int RESTART_DELAY_LSB = 0;

   // ----------------------------------------------------------------
   // Values after reset
   // ----------------------------------------------------------------
   localparam logic [7:0] CMP_RBT_PIN_SEL_RESET = 8'h05;
   localparam logic [5:0] REBOOT_CTRL_RESET = 6'h00;
   localparam logic SWITCH_ON_RESET = 1'b1;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int unsigned CLK_PERIOD_PS = 8000;
   localparam int unsigned MS_IN_PS = 1000000000;
   localparam int unsigned CYC_PER_MS = MS_IN_PS / CLK_PERIOD_PS;
   // Turn-on delay per code, in milliseconds
   localparam logic [16:0] RESTART_WAIT_TIME_MS [8] = '{
      17'd580, 17'd1160, 17'd2320, 17'd4640,
      17'd9280, 17'd18600, 17'd37100, 17'd74200};

   // ----------------------------------------------------------------
   // Sequencer states
   // ----------------------------------------------------------------
   typedef enum logic [0:0] {
      RBS_IDLE = 1'b0,
      RBS_OFF = 1'b1
   } rbs_state_e;

endpackage

// ===== hdl/rbs_tmr_if.sv
// Interface: start, delay code and expiry between sequencer and delay timer
interface rbs_tmr_if;
   logic start;
   logic [2:0] code;
   logic expired;

   modport ctrl (output start, output code, input expired);
   modport timer (input start, input code, output expired);
endinterface

// ===== hdl/rbs_delay_timer.sv
// Module: millisecond-based turn-on delay timer
module rbs_delay_timer #(
   parameter int unsigned TICK_CYCLES = rbs_pkg::CYC_PER_MS
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Sequencer side
   rbs_tmr_if.timer tmr
);
   import rbs_pkg::*;

   typedef struct packed {
      logic run;
      logic [31:0] pre;
      logic [16:0] ms;
      logic [16:0] limit;
      logic expired;
   } rbs_tmr_s;

   rbs_tmr_s s;
   rbs_tmr_s next_s;

   always_comb
   begin
      next_s = s;
      next_s.expired = 1'b0;
      if (tmr.start)
      begin
         // A new start restarts the wait from zero
         next_s.run = 1'b1;
         next_s.pre = 32'h0;
         next_s.ms = 17'h0;
         next_s.limit = RESTART_WAIT_TIME_MS[tmr.code];
      end
      else if (s.run)
      begin
         if (s.pre == TICK_CYCLES - 1)
         begin
            next_s.pre = 32'h0;
            if (s.ms == s.limit - 17'h1)
            begin
               next_s.run = 1'b0;
               next_s.expired = 1'b1;
            end
            else
            begin
               next_s.ms = s.ms + 17'h1;
            end
         end
         else
         begin
            next_s.pre = s.pre + 32'h1;
         end
      end
   end

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         s <= '0;
      end
      else
      begin
         s <= next_s;
      end
   end

   assign tmr.expired = s.expired;

   a_expiry_after_run: assert property (@(posedge clk) disable iff (!rstn)
      s.expired |-> $past(s.run) && !s.run)
      else $error("expiry without a running wait");

endmodule

// ===== hdl/rbs_reboot_sequencer.sv
// Module: reboot sequencer with comparator input and reboot pin selection
module rbs_reboot_sequencer #(
   parameter int unsigned TICK_CYCLES = rbs_pkg::CYC_PER_MS
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Register access by command code
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_rd,
   output logic [15:0] reg_rdata,
   output logic reg_rvalid,
   // General-purpose pins, asynchronous
   input wire logic [7:0] gpio_in,
   // Comparator and power control
   output logic cmp_in,
   output logic switch_on,
   output logic chip_reset,
   output logic reboot_busy
);
   import rbs_pkg::*;

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [7:0] pin_sel;
      logic [5:0] rbt_ctl;
      rbs_state_e st;
      logic [7:0] gpio_s1;
      logic [7:0] gpio_s2;
      logic [7:0] gpio_s3;
      logic cmp_in;
      logic sw_on;
      logic chip_rst;
      logic tstart;
      logic [2:0] tcode;
      logic [15:0] rdata;
      logic rvalid;
   } rbs_seq_s;

   rbs_seq_s s;
   rbs_seq_s next_s;
   rbs_tmr_if tmr ();

   logic [2:0] comparator_input_pick;
   logic [2:0] restart_trigger_pin_pick;
   logic pin_restart_enable;
   logic [1:0] restart_init_mode;
   logic [2:0] restart_turn_on_delay;
   logic wr_ctl;
   logic cmd_start;
   logic pin_start;
   logic start;

   assign comparator_input_pick = s.pin_sel[CMP_PICK_LSB +: 3];
   assign restart_trigger_pin_pick = s.pin_sel[RESTART_PIN_PICK_LSB +: 3];
   assign pin_restart_enable = s.pin_sel[PIN_RESTART_ENABLE_BIT];
   assign restart_init_mode = s.rbt_ctl[RESTART_INIT_MODE_LSB +: 2];
   assign restart_turn_on_delay = s.rbt_ctl[RESTART_DELAY_LSB +: 3];

   assign wr_ctl = reg_wr && (reg_addr == REBOOT_CTRL_ADDR);
   assign cmd_start = wr_ctl && reg_wdata[REBOOT_CMD_BIT];
   // Rising edge of the picked pin, seen only after two sync stages
   assign pin_start = pin_restart_enable && s.gpio_s2[restart_trigger_pin_pick]
                      && !s.gpio_s3[restart_trigger_pin_pick];
   assign start = cmd_start || pin_start;

   // ----------------------------------------------------------------
   // Next-state logic
   // ----------------------------------------------------------------
   always_comb
   begin
      next_s = s;
      next_s.tstart = 1'b0;
      next_s.rvalid = reg_rd;
      next_s.gpio_s1 = gpio_in;
      next_s.gpio_s2 = s.gpio_s1;
      next_s.gpio_s3 = s.gpio_s2;
      next_s.cmp_in = s.gpio_s2[comparator_input_pick];

      if (reg_wr && reg_addr == CMP_RBT_PIN_SEL_ADDR)
      begin
         // Reserved upper byte and bit 3 are not stored
         next_s.pin_sel = {reg_wdata[7:4], 1'b0, reg_wdata[2:0]};
      end
      if (wr_ctl)
      begin
         // Bit 3 is never cleared by the sequence itself, only by a write
         next_s.rbt_ctl = reg_wdata[5:0];
      end

      if (start)
      begin
         // Delay taken from the value being written when the command starts it
         next_s.tcode = cmd_start ? reg_wdata[RESTART_DELAY_LSB +: 3] : restart_turn_on_delay;
         next_s.tstart = 1'b1;
         next_s.st = RBS_OFF;
         next_s.sw_on = 1'b0;
         next_s.chip_rst = cmd_start ? !reg_wdata[RESTART_INIT_MODE_LSB + 1]
                                     : !restart_init_mode[1];
      end
      else
      begin
         case (s.st)
            RBS_IDLE:
            begin
               next_s.sw_on = 1'b1;
               next_s.chip_rst = 1'b0;
            end
            RBS_OFF:
            begin
               if (tmr.expired)
               begin
                  next_s.st = RBS_IDLE;
                  next_s.sw_on = 1'b1;
                  next_s.chip_rst = 1'b0;
               end
            end
            default:
            begin
               next_s.st = RBS_IDLE;
            end
         endcase
      end

      case (reg_addr)
         CMP_RBT_PIN_SEL_ADDR: next_s.rdata = {8'h00, s.pin_sel};
         REBOOT_CTRL_ADDR: next_s.rdata = {10'h000, s.rbt_ctl};
         default: next_s.rdata = 16'h0000;
      endcase
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         s <= '0;
         s.pin_sel <= CMP_RBT_PIN_SEL_RESET;
         s.rbt_ctl <= REBOOT_CTRL_RESET;
         s.st <= RBS_IDLE;
         s.sw_on <= SWITCH_ON_RESET;
      end
      else
      begin
         s <= next_s;
      end
   end

   assign tmr.start = s.tstart;
   assign tmr.code = s.tcode;

   rbs_delay_timer #(
      .TICK_CYCLES(TICK_CYCLES)
   ) u_timer (
      .clk(clk),
      .rstn(rstn),
      .tmr(tmr)
   );

   assign reg_rdata = s.rdata;
   assign reg_rvalid = s.rvalid;
   assign cmp_in = s.cmp_in;
   assign switch_on = s.sw_on;
   assign chip_reset = s.chip_rst;
   assign reboot_busy = (s.st == RBS_OFF);

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   // Expected pin spelled out for picks 5 to 7 so a wrong index in the mux is caught
   a_cmp_high_route: assert property (@(posedge clk) disable iff (!rstn)
      comparator_input_pick[2] && (comparator_input_pick != 3'h4) |=>
      cmp_in == $past(comparator_input_pick == 3'h5 ? s.gpio_s2[5] :
                      (comparator_input_pick == 3'h6 ? s.gpio_s2[6] : s.gpio_s2[7])))
      else $error("comparator input not routed from picked pin");

   a_chip_reset_mode: assert property (@(posedge clk) disable iff (!rstn)
      cmd_start && !reg_wdata[5] |=> chip_reset && !switch_on)
      else $error("chip reset missing for init mode 0x");

   a_no_reset_mode: assert property (@(posedge clk) disable iff (!rstn)
      cmd_start && reg_wdata[5:4] == 2'b10 |=> !chip_reset && !switch_on ##1 !chip_reset)
      else $error("chip reset raised in no-reset mode");

   a_cmd_switch_off: assert property (@(posedge clk) disable iff (!rstn)
      cmd_start |=> !switch_on && reboot_busy ##1 tmr.start == 1'b0)
      else $error("reboot command did not turn the switch off");

   a_cmd_bit_kept: assert property (@(posedge clk) disable iff (!rstn)
      tmr.expired && s.rbt_ctl[REBOOT_CMD_BIT] && !wr_ctl |=> s.rbt_ctl[REBOOT_CMD_BIT])
      else $error("reboot bit cleared by the sequence");

   a_on_after_expiry: assert property (@(posedge clk) disable iff (!rstn)
      $rose(switch_on) |-> $past(tmr.expired))
      else $error("switch restored before the wait expired");

   a_pin_trigger: assert property (@(posedge clk) disable iff (!rstn)
      pin_start && !cmd_start |=> !switch_on && chip_reset == !$past(restart_init_mode[1]))
      else $error("pin trigger did not start a reboot");

   a_reserved_zero: assert property (@(posedge clk) disable iff (!rstn)
      reg_rvalid && $past(reg_addr) == REBOOT_CTRL_ADDR |-> reg_rdata[15:6] == 10'h000)
      else $error("reserved reboot control bits read nonzero");

   c_cmd_reboot: cover property (@(posedge clk) disable iff (!rstn)
      cmd_start ##1 (!switch_on && reboot_busy));
   c_restore: cover property (@(posedge clk) disable iff (!rstn)
      reboot_busy && tmr.expired ##1 (switch_on && !reboot_busy));
   c_pin_reboot: cover property (@(posedge clk) disable iff (!rstn)
      pin_start ##1 reboot_busy);
   c_no_reset: cover property (@(posedge clk) disable iff (!rstn)
      cmd_start && reg_wdata[5:4] == 2'b10);
   c_restart_busy: cover property (@(posedge clk) disable iff (!rstn)
      reboot_busy && start);

endmodule

// ===== bench/rbs_host_model.sv
// Host model: issues register writes and reads by command code
module rbs_host_model
(
   // Clock
   input wire logic clk,
   // Register port towards the sequencer
   output logic [7:0] reg_addr,
   output logic reg_wr,
   output logic [15:0] reg_wdata,
   output logic reg_rd,
   input wire logic [15:0] reg_rdata,
   input wire logic reg_rvalid
);
   timeunit 1ns;
   timeprecision 100ps;

   initial
   begin
      reg_addr = 8'h00;
      reg_wr = 1'b0;
      reg_wdata = 16'h0000;
      reg_rd = 1'b0;
   end

   // Released lines show the inverse so stale values never pass
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
      reg_addr <= ~a;
      reg_wdata <= ~d;
   endtask

   task automatic rd(input logic [7:0] a, output logic [15:0] d, output logic v);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      reg_addr <= ~a;
      #1;
      d = reg_rdata;
      v = reg_rvalid;
   endtask
endmodule

// ===== bench/test_reboot_sequencer_cmp_select.sv
// Testbench: register map, comparator pick, reboot and pin trigger
module test_reboot_sequencer_cmp_select;
   timeunit 1ns;
   timeprecision 100ps;
   import rbs_pkg::*;

   // Short tick keeps the delays to a few thousand cycles
   localparam int unsigned TICK = 2;
   logic clk;
   logic rstn;
   logic [7:0] reg_addr;
   logic reg_wr;
   logic [15:0] reg_wdata;
   logic reg_rd;
   logic [15:0] reg_rdata;
   logic reg_rvalid;
   logic [7:0] gpio_in;
   logic cmp_in;
   logic switch_on;
   logic chip_reset;
   logic reboot_busy;
   int n_errors = 0;
   int compares = 0;
   logic [15:0] rdat;
   logic rv;

   rbs_reboot_sequencer #(.TICK_CYCLES(TICK)) dut (.clk(clk), .rstn(rstn), .reg_addr(reg_addr),
      .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .reg_rvalid(reg_rvalid), .gpio_in(gpio_in), .cmp_in(cmp_in), .switch_on(switch_on),
      .chip_reset(chip_reset), .reboot_busy(reboot_busy));
   rbs_host_model host (.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));

   task automatic check_word(input logic [15:0] got, input logic [15:0] exp, input string what);
      compares++;
      if (got !== exp)
         $display("unexpected %0t %s got %h exp %h", $time, what, got, exp);
      if (got !== exp)
         n_errors++;
   endtask

   task automatic check_bit(input logic got, input logic exp, input string what);
      compares++;
      if (got !== exp)
         $display("unexpected %0t %s got %b exp %b", $time, what, got, exp);
      if (got !== exp)
         n_errors++;
   endtask

   task automatic read_check(input logic [7:0] a, input logic [15:0] exp);
      host.rd(a, rdat, rv);
      check_bit(rv, 1'b1, "read answer");
      check_word(rdat, exp, "read data");
   endtask

   task automatic t_reset_and_map();
      read_check(CMP_RBT_PIN_SEL_ADDR, 16'h0005);
      read_check(REBOOT_CTRL_ADDR, 16'h0000);
      check_bit(switch_on, 1'b1, "switch after reset");
      host.wr(8'h42, 16'hffff);
      read_check(8'h42, 16'h0000);
      host.wr(CMP_RBT_PIN_SEL_ADDR, 16'hff7f);
      read_check(CMP_RBT_PIN_SEL_ADDR, 16'h0077);
      host.wr(REBOOT_CTRL_ADDR, 16'hfff7);
      read_check(REBOOT_CTRL_ADDR, 16'h0037);
      check_bit(switch_on, 1'b1, "no reboot without command");
   endtask

   // Pin edges here also prove the trigger stays off while disabled
   task automatic t_cmp();
      for (int i = 0; i < 8; i++)
      begin
         host.wr(CMP_RBT_PIN_SEL_ADDR, 16'(i));
         gpio_in <= 8'h01 << i;
         repeat (5) @(posedge clk);
         check_bit(cmp_in, 1'b1, "picked pin high");
         gpio_in <= ~(8'h01 << i);
         repeat (5) @(posedge clk);
         check_bit(cmp_in, 1'b0, "picked pin low");
      end
      gpio_in <= 8'h00;
      check_bit(switch_on, 1'b1, "pin trigger disabled");
   endtask

   task automatic wait_switch(input logic lvl, input int lim, output int n);
      n = 0;
      while (switch_on !== lvl && n < lim)
      begin
         @(posedge clk);
         #1;
         n++;
      end
   endtask

   task automatic t_reboot(input logic [1:0] mode, input logic [2:0] code, input logic exp_rst);
      int n;
      int w;
      w = RESTART_WAIT_TIME_MS[code] * TICK;
      host.wr(REBOOT_CTRL_ADDR, {10'h000, mode, 1'b1, code});
      #1;
      check_bit(switch_on, 1'b0, "switch off");
      check_bit(chip_reset, exp_rst, "chip reset");
      check_bit(reboot_busy, 1'b1, "busy");
      wait_switch(1'b1, w + 20, n);
      check_bit(n >= w - 2 && n <= w + 4, 1'b1, "turn-on delay");
      check_bit(chip_reset, 1'b0, "reset released");
      check_bit(reboot_busy, 1'b0, "busy cleared");
      read_check(REBOOT_CTRL_ADDR, {10'h000, mode, 1'b1, code});
   endtask

   // Longest code must still be off after twice the shortest wait; a new command restarts the wait
   task automatic t_restart();
      int n;
      int w;
      w = RESTART_WAIT_TIME_MS[0] * TICK;
      host.wr(REBOOT_CTRL_ADDR, 16'h002f);
      #1;
      wait_switch(1'b1, 2 * w, n);
      check_bit(switch_on, 1'b0, "long delay still off");
      check_bit(reboot_busy, 1'b1, "long delay busy");
      host.wr(REBOOT_CTRL_ADDR, 16'h0028);
      #1;
      check_bit(switch_on, 1'b0, "restart keeps switch off");
      wait_switch(1'b1, w + 20, n);
      check_bit(n >= w - 2 && n <= w + 4, 1'b1, "restarted delay");
      check_bit(reboot_busy, 1'b0, "restart busy cleared");
   endtask

   task automatic t_pin(input logic [2:0] sel);
      int n;
      host.wr(REBOOT_CTRL_ADDR, 16'h0020);
      host.wr(CMP_RBT_PIN_SEL_ADDR, {8'h00, 1'b1, sel, 4'h5});
      @(posedge clk);
      gpio_in <= 8'h01 << sel;
      wait_switch(1'b0, 10, n);
      check_bit(n <= 6, 1'b1, "pin trigger");
      check_bit(chip_reset, 1'b0, "no reset in mode 10");
      wait_switch(1'b1, 1300, n);
      check_bit(n >= 1158 && n <= 1166, 1'b1, "pin turn-on delay");
      read_check(REBOOT_CTRL_ADDR, 16'h0020);
      gpio_in <= 8'h00;
   endtask

   task automatic close_out();
      $display("errors %0d compares %0d", n_errors, compares);
      if (n_errors == 0 && compares > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   initial
   begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   initial
   begin
      rstn = 1'b0;
      gpio_in = 8'h00;
      repeat (5) @(posedge clk);
      rstn <= 1'b1;
      t_reset_and_map();
      t_cmp();
      t_reboot(2'b00, 3'b000, 1'b1);
      t_reboot(2'b01, 3'b001, 1'b1);
      t_reboot(2'b10, 3'b010, 1'b0);
      t_reboot(2'b11, 3'b011, 1'b0);
      t_restart();
      t_pin(3'd6);
      close_out();
   end

   // About 23000 cycles expected; cut off at 50000
   initial
   begin
      #400000;
      n_errors++;
      $display("unexpected %0t watchdog expired", $time);
      close_out();
   end
endmodule
